//--- design/dmdc_map.svh
/*
 * Constant map of the calibration-readout / DLL-off command block: mode register
 * field positions, command encodings, burst codes and the calibration pattern.
 * Assumes inclusion by bare name from the package; the design top uses its macros without including it.
 */
`ifndef DMDC_MAP_SVH
`define DMDC_MAP_SVH
// Command encodings {ras_n, cas_n, we_n} with chip select low
`define DMDC_CMD_MRS 3'h0
`define DMDC_CMD_REF 3'h1
`define DMDC_CMD_READ 3'h5
`define DMDC_CMD_NOP 3'h7
// Mode register select on bank address
`define DMDC_MR_ZERO 3'h0
`define DMDC_MR_ONE 3'h1
`define DMDC_MR_TWO 3'h2
`define DMDC_MR_THREE 3'h3
// Field positions
`define DMDC_MR3_CAL_EN 2
`define DMDC_MR1_DLL_OFF 0
`define DMDC_ADDR_BC 12
`define DMDC_ADDR_NIBBLE 2
// Burst length field codes of mode_reg_zero
`define DMDC_BL_FIXED8 2'h0
`define DMDC_BL_OTF 2'h1
// Latency code offsets and the DLL-off only setting
`define DMDC_CL_BASE 6'h04
`define DMDC_CWL_BASE 6'h05
`define DMDC_DLL_OFF_LAT 6'h06
// Additive latency codes
`define DMDC_AL_CLM1 2'h1
`define DMDC_AL_CLM2 2'h2
// Calibration location 00b pattern, beat 0 in the LSB
`define DMDC_CAL_PATTERN 8'h_AA
`define DMDC_CAL_LOC0 2'h0
`define DMDC_REG_RESET 16'h0000
`endif

//--- design/dmdc_pkg.sv
/*
 * Types of the calibration-readout / DLL-off command block.
 * Assumes the constant map header is on the include path.
 */
package dmdc_pkg;
    `include "dmdc_map.svh"
    // One sampled command bus word
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
    } dmdc_cmd_t;
    // One read data beat
    typedef struct packed {
        logic [7:0] dq;
        logic upper_data_line_zero;
        logic last;
    } dmdc_beat_t;
endpackage : dmdc_pkg

//--- design/dmdc_fifo.sv
/*
 * Synchronous valid/ready FIFO for read data beats.
 * Assumes one clock, asynchronous active-low reset and a freezing clock enable.
 */
`timescale 1ns/100ps
module dmdc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH]; // Beat storage
    logic [AW-1:0] wr_ptr_reg; // Write index
    logic [AW-1:0] rd_ptr_reg; // Read index
    logic [AW:0] count_reg; // Fill level
    logic push; // Accepted write
    logic pop; // Accepted read
    assign in_ready_o = (count_reg != (AW+1)'(DEPTH)) && ce_i;
    assign out_valid_o = (count_reg != '0) && ce_i;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_ptr_reg];
    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end
    // Pointers and level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dmdc_fifo

//--- design/dmdc_top.sv
/*
 * Device-side command decoder of a DDR3 x8 memory for calibration-pattern
 * readout, no-operation / deselect, DLL-off read latency and the DLL switch
 * through self-refresh. Read beats leave through an 8-deep FIFO as a stream.
 * Assumes the link clock and command pins arrive asynchronously and are much
 * slower than clk_i; the controller keeps its own side of the protocol.
 */
// Operation
// R1 - Mode register three bit two enables calibration readout
// R2 - In calibration mode only reads; autoprecharge ignored
// R3 - Bit on line zero; others repeat or zero
// R4 - Controller keeps column bits one, zero at 00
// R5 - Full burst: address bit two zero, order 0..7
// R6 - Chopped burst: bit two picks nibble
// R7 - Bit twelve chops on the fly if enabled
// R8 - Bank, bit ten, upper columns ignored
// R9 - Calibration reads use normal read latency
// R10 - Controller reads calibration only after DLL lock
// R11 - Beat zero is LSB, beat seven MSB
// R12 - Location zero gives 0101 pattern; others reserved
// R13 - NOP registers nothing, work continues
// R14 - Deselect takes no command, work continues
// R15 - Mode register one bit zero disables DLL
// R16 - DLL-off supports only CL six, CAS_WRITE_LATENCY six
// R17 - DLL-off read data starts AL+CL-1 cycles
// R18 - Controller keeps DLL-off clock below maximum
// R19 - Controller idles, terminations off before DLL disable
// R20 - Controller waits, enters self-refresh, changes clock
// R21 - Clock enable held high after self-refresh exit
// R22 - Termination held low when enabled at entry
// R23 - Controller reprograms latencies after exit delay
`timescale 1ns/100ps
module dmdc_top #(
    parameter int FIFO_DEPTH = 8,
    parameter bit MIRROR_DQ = 1'b1,
    parameter int MODE_UPDATE_NCK = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_ck_i,
    input wire dmdc_pkg::dmdc_cmd_t cmd_pins_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output dmdc_pkg::dmdc_beat_t rd_beat_o,
    output logic cal_mode_o,
    output logic dll_off_o,
    output logic self_refresh_o,
    output logic mode_update_busy_o,
    output logic dll_off_latency_bad_o,
    output logic cmd_refused_o,
    output logic [5:0] read_latency_o
);
    import dmdc_pkg::*;

    localparam int SW = $bits(dmdc_cmd_t) + 1; // Sampled pin count
    typedef enum logic [1:0] {IDLE, WAIT_LAT, BURST} dmdc_state_t;

    // Three-stage pin synchroniser and agreed value
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] sync3_reg;
    logic [SW-1:0] stable_reg;
    logic ck_prev_reg; // Link clock level at previous agreement
    logic ck_rise; // Link clock rising edge seen
    dmdc_cmd_t cmd; // Command word at the edge
    logic [2:0] opcode; // {ras_n, cas_n, we_n}

    // Mode registers
    logic [15:0] mr0_reg;
    logic [15:0] mr1_reg;
    logic [15:0] mr2_reg;
    logic [15:0] mr3_reg;
    logic [7:0] mod_cnt_reg; // Mode update delay in link cycles
    logic sr_reg; // Self-refresh state
    logic refused_reg; // Refused command pulse

    // Read engine
    dmdc_state_t state_reg;
    logic [5:0] lat_cnt_reg; // Link cycles left before data
    logic [2:0] beat_idx_reg; // Current beat position
    logic [3:0] beats_left_reg; // Beats still to emit
    logic cal_read_reg; // Burst is a calibration read
    logic [1:0] cal_loc_reg; // Location latched at read
    logic [5:0] cl; // Decoded CAS latency
    logic [5:0] cas_write_latency; // Decoded CAS write latency
    logic [5:0] al; // Decoded additive latency
    logic [5:0] rl; // Read latency in link cycles
    logic chop; // Burst chop selected
    logic fifo_ready; // FIFO can take a beat
    logic beat_push; // Beat is written this cycle
    dmdc_beat_t beat; // Beat being built

    // Decode of {ras_n, cas_n, we_n} when chip select is low
    function automatic logic is_cmd(input dmdc_cmd_t c, input logic [2:0] code);
        is_cmd = !c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == code);
    endfunction : is_cmd

    // Per-pin synchroniser; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                    sync3_reg[gi] <= 1'b1;
                    stable_reg[gi] <= 1'b1;
                end else if (ce_i) begin
                    sync1_reg[gi] <= (gi == SW - 1) ? link_ck_i : cmd_pins_i[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // Only update on agreement
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        stable_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    assign cmd = stable_reg[SW-2:0];
    assign opcode = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign ck_rise = stable_reg[SW-1] && !ck_prev_reg;

    // Link clock edge finder
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ck_prev_reg <= 1'b1;
        end else if (ce_i) begin
            ck_prev_reg <= stable_reg[SW-1];
        end
    end

    // Latency decode from the mode registers
    always_comb begin
        cl = `DMDC_CL_BASE + {3'h0, mr0_reg[6:4]};
        cas_write_latency = `DMDC_CWL_BASE + {3'h0, mr2_reg[5:3]};
        // Additive latency choices
        case (mr1_reg[4:3])
            `DMDC_AL_CLM1: al = cl - 6'h01;
            `DMDC_AL_CLM2: al = cl - 6'h02;
            default: al = 6'h00;
        endcase
        // DLL-off data one cycle earlier
        if (mr1_reg[`DMDC_MR1_DLL_OFF]) begin
            rl = al + cl - 6'h01; // R17
        end else begin
            rl = al + cl; // R9
        end
    end

    // Burst chop: fixed by mode register or by bit twelve when on the fly
    always_comb begin
        case (mr0_reg[1:0])
            `DMDC_BL_FIXED8: chop = 1'b0;
            `DMDC_BL_OTF: chop = !cmd.addr[`DMDC_ADDR_BC]; // R7
            default: chop = 1'b1; // R7
        endcase
    end

    // Mode register writes; a no-op or deselect stores nothing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mr0_reg <= `DMDC_REG_RESET;
            mr1_reg <= `DMDC_REG_RESET;
            mr2_reg <= `DMDC_REG_RESET;
            mr3_reg <= `DMDC_REG_RESET;
        end else if (ce_i && ck_rise && cmd.cke && !sr_reg &&
                     is_cmd(cmd, `DMDC_CMD_MRS)) begin // R13 R14
            // Bank address picks the register
            case (cmd.ba)
                `DMDC_MR_ZERO: mr0_reg <= cmd.addr;
                `DMDC_MR_ONE: mr1_reg <= cmd.addr; // R15
                `DMDC_MR_TWO: mr2_reg <= cmd.addr;
                `DMDC_MR_THREE: mr3_reg <= cmd.addr; // R1
                default: ;
            endcase
        end
    end

    // Mode update delay after every mode register write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_cnt_reg <= '0;
        end else if (ce_i && ck_rise) begin
            if (cmd.cke && !sr_reg && is_cmd(cmd, `DMDC_CMD_MRS)) begin
                mod_cnt_reg <= 8'(MODE_UPDATE_NCK);
            end else if (mod_cnt_reg != '0) begin
                mod_cnt_reg <= mod_cnt_reg - 8'h01;
            end
        end
    end

    // Self-refresh entry on refresh with clock enable low, exit on it high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_reg <= 1'b0;
        end else if (ce_i && ck_rise) begin
            if (!sr_reg && !cmd.cke && is_cmd(cmd, `DMDC_CMD_REF)) begin
                sr_reg <= 1'b1;
            end else if (sr_reg && cmd.cke) begin
                sr_reg <= 1'b0;
            end
        end
    end

    // Refused commands: in calibration mode anything but read, mode set or no-op, or a read while the engine is not idle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            refused_reg <= 1'b0;
        end else if (ce_i) begin
            refused_reg <= 1'b0;
            if (ck_rise && cmd.cke && !sr_reg && !cmd.cs_n) begin
                if (mr3_reg[`DMDC_MR3_CAL_EN] && opcode != `DMDC_CMD_READ &&
                    opcode != `DMDC_CMD_MRS && opcode != `DMDC_CMD_NOP) begin
                    refused_reg <= 1'b1; // R2
                end else if (opcode == `DMDC_CMD_READ && state_reg != IDLE) begin
                    refused_reg <= 1'b1;
                end
            end
        end
    end

    // Read state machine: latency wait, then one beat per clk_i cycle in which the FIFO accepts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= IDLE;
            lat_cnt_reg <= '0;
            beat_idx_reg <= '0;
            beats_left_reg <= '0;
            cal_read_reg <= 1'b0;
            cal_loc_reg <= '0;
        end else if (ce_i) begin
            case (state_reg)
                IDLE: begin
                    // Read or read with autoprecharge share one opcode
                    if (ck_rise && cmd.cke && !sr_reg &&
                        is_cmd(cmd, `DMDC_CMD_READ)) begin // R2 R13 R14
                        state_reg <= WAIT_LAT;
                        lat_cnt_reg <= rl - 6'h01; // R9
                        cal_read_reg <= mr3_reg[`DMDC_MR3_CAL_EN]; // R1
                        cal_loc_reg <= mr3_reg[1:0];
                        // Only column bits two and twelve steer the burst
                        beat_idx_reg <= chop ? {cmd.addr[`DMDC_ADDR_NIBBLE], 2'h0}
                                             : 3'h0; // R5 R6 R8
                        beats_left_reg <= chop ? 4'h4 : 4'h8; // R7
                    end
                end
                WAIT_LAT: begin
                    // Count link clock edges up to the read latency
                    if (ck_rise) begin
                        if (lat_cnt_reg == '0) begin
                            state_reg <= BURST;
                        end else begin
                            lat_cnt_reg <= lat_cnt_reg - 6'h01;
                        end
                    end
                end
                BURST: begin
                    // Beats advance only while the FIFO accepts
                    if (beat_push) begin
                        beat_idx_reg <= beat_idx_reg + 3'h1; // R5 R6
                        beats_left_reg <= beats_left_reg - 4'h1;
                        if (beats_left_reg == 4'h1) begin
                            state_reg <= IDLE;
                        end
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // Beat builder: pattern bit chosen by beat position
    always_comb begin
        logic bit_val;
        bit_val = 1'b0;
        // Reserved locations and array reads return zero
        if (cal_read_reg && cal_loc_reg == `DMDC_CAL_LOC0) begin
            bit_val = 1'(`DMDC_CAL_PATTERN >> beat_idx_reg); // R11 R12
        end
        beat.dq = MIRROR_DQ ? {8{bit_val}} : {7'h00, bit_val}; // R3
        beat.upper_data_line_zero = bit_val; // R3
        beat.last = (beats_left_reg == 4'h1);
    end

    assign beat_push = (state_reg == BURST) && fifo_ready;

    // Beat buffer toward the data consumer
    dmdc_fifo #(
        .WIDTH($bits(dmdc_beat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(state_reg == BURST),
        .in_ready_o(fifo_ready),
        .in_data_i(beat),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_beat_o)
    );

    // Status outputs
    assign cal_mode_o = mr3_reg[`DMDC_MR3_CAL_EN]; // R1
    assign dll_off_o = mr1_reg[`DMDC_MR1_DLL_OFF]; // R15
    assign self_refresh_o = sr_reg;
    assign mode_update_busy_o = (mod_cnt_reg != '0);
    assign dll_off_latency_bad_o = dll_off_o &&
        ((cl != `DMDC_DLL_OFF_LAT) || (cas_write_latency != `DMDC_DLL_OFF_LAT)); // R16
    assign cmd_refused_o = refused_reg;
    assign read_latency_o = rl;
endmodule : dmdc_top

//--- verification/dmdc_checker.sv
/*
 * Port assertions of the calibration-readout / DLL-off command block.
 * Assumes a bind onto dmdc_top and one clock domain with async reset.
 */
`timescale 1ns/100ps
module dmdc_checker #(
    parameter int MODE_UPDATE_NCK = 12,
    parameter bit MIRROR_DQ = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_ck_i,
    input wire dmdc_pkg::dmdc_cmd_t cmd_pins_i,
    input wire logic rd_valid_o,
    input wire logic rd_ready_i,
    input wire dmdc_pkg::dmdc_beat_t rd_beat_o,
    input wire logic cal_mode_o,
    input wire logic dll_off_o,
    input wire logic self_refresh_o,
    input wire logic mode_update_busy_o,
    input wire logic dll_off_latency_bad_o,
    input wire logic cmd_refused_o,
    input wire logic [5:0] read_latency_o
);
    import dmdc_pkg::*;
    // Longest busy stretch: the update count in link periods plus sync slack
    localparam int BUSY_MAX = MODE_UPDATE_NCK * 32 + 64;
    logic [11:0] busy_cnt_reg; // Cycles of continuous busy
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Busy length counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt_reg <= 12'h000;
        end else begin
            busy_cnt_reg <= mode_update_busy_o ? busy_cnt_reg + 12'h001 : 12'h000;
        end
    end
    beat_hold_a: assert property (rd_valid_o && !rd_ready_i && ce_i |=>
        rd_valid_o && $stable(rd_beat_o)) else $error("beat changed while stalled");
    mirror_dq_a: assert property (rd_valid_o |-> rd_beat_o.dq == (MIRROR_DQ ?
        {8{rd_beat_o.upper_data_line_zero}} : {7'h00, rd_beat_o.upper_data_line_zero}))
        else $error("data lines disagree with line zero");
    refuse_pulse_a: assert property (cmd_refused_o |=> !cmd_refused_o)
        else $error("refusal pulse longer than one cycle");
    dll_bad_a: assert property (dll_off_latency_bad_o |-> dll_off_o)
        else $error("latency flag without DLL off");
    dll_latency_a: assert property (dll_off_o && !dll_off_latency_bad_o |->
        read_latency_o inside {6'h05, 6'h09, 6'h0a}) else $error("DLL-off latency wrong");
    mode_by_mrs_a: assert property ($changed(cal_mode_o) || $changed(dll_off_o) |->
        $past(cmd_pins_i.cs_n, 6) == 1'b0 &&
        $past({cmd_pins_i.ras_n, cmd_pins_i.cas_n, cmd_pins_i.we_n}, 6) == 3'h0)
        else $error("mode changed without a selected mode set");
    sr_entry_a: assert property ($rose(self_refresh_o) |->
        $past(cmd_pins_i.cke, 6) == 1'b0) else $error("self-refresh without low enable");
    busy_after_mrs_a: assert property ($changed(dll_off_o) || $changed(cal_mode_o) |->
        ##[0:2] mode_update_busy_o) else $error("no update delay after mode set");
    busy_bound_a: assert property (busy_cnt_reg < BUSY_MAX)
        else $error("update delay too long");
endmodule : dmdc_checker

bind dmdc_top dmdc_checker #(.MODE_UPDATE_NCK(MODE_UPDATE_NCK), .MIRROR_DQ(MIRROR_DQ))
    u_dmdc_checker (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link_ck_i(link_ck_i),
    .cmd_pins_i(cmd_pins_i), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .rd_beat_o(rd_beat_o), .cal_mode_o(cal_mode_o), .dll_off_o(dll_off_o),
    .self_refresh_o(self_refresh_o), .mode_update_busy_o(mode_update_busy_o),
    .dll_off_latency_bad_o(dll_off_latency_bad_o), .cmd_refused_o(cmd_refused_o),
    .read_latency_o(read_latency_o));

//--- verification/dmdc_ctrl_model.sv
/*
 * Memory controller model: free-running link clock and command pins.
 * Assumes the bench calls send() once per command, in protocol order.
 */
`timescale 1ns/100ps
module dmdc_ctrl_model (
    output logic link_ck_o,
    output dmdc_pkg::dmdc_cmd_t cmd_o
);
    import dmdc_pkg::*;
    // Link clock at 160 ns, well under the DLL-off ceiling
    initial begin
        link_ck_o = 1'b0;
        cmd_o = 24'hff_ffff;
        forever #80 link_ck_o = ~link_ck_o;
    end
    // Command launched on a falling edge and held a whole period
    task automatic send(input dmdc_cmd_t c);
        @(negedge link_ck_o);
        cmd_o <= c;
        @(negedge link_ck_o);
        // Deselect after; enable level kept, other lines inverted; no termination driven
        cmd_o <= {c.cke, 1'b1, ~c.ras_n, ~c.cas_n, ~c.we_n, ~c.ba, ~c.addr};
    endtask : send
endmodule : dmdc_ctrl_model

//--- verification/dmdc_top_test.sv
/*
 * Self-checking bench of the command block: a queue model predicts beats.
 * Assumes the controller model and checker files are compiled first.
 */
`timescale 1ns/100ps
module dmdc_top_test;
    import dmdc_pkg::*;
    logic clk_i, rst_n_i, ce_i, link_ck, rd_valid_o, rd_ready_i, cal_mode_o, dll_off_o;
    logic self_refresh_o, busy, bad, cmd_refused_o, stall;
    logic [5:0] rl;
    dmdc_cmd_t cmd_pins;
    dmdc_beat_t rd_beat_o;
    logic [9:0] q[$]; // Expected beats
    int n_mismatch, checked, n_refused, cycles, burst, cal, loc, base;
    dmdc_ctrl_model u_dmdc_ctrl_model (.link_ck_o(link_ck), .cmd_o(cmd_pins));
    dmdc_top u_dmdc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link_ck_i(link_ck),
        .cmd_pins_i(cmd_pins), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
        .rd_beat_o(rd_beat_o), .cal_mode_o(cal_mode_o), .dll_off_o(dll_off_o),
        .self_refresh_o(self_refresh_o), .mode_update_busy_o(busy),
        .dll_off_latency_bad_o(bad), .cmd_refused_o(cmd_refused_o), .read_latency_o(rl));
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // Command word {cs_n, ras_n, cas_n, we_n} through the controller model
    task automatic cmd(input logic cke, input logic [3:0] w, input logic [2:0] ba,
                       input logic [15:0] a);
        u_dmdc_ctrl_model.send({cke, w, ba, a});
    endtask : cmd
    // Mode set, then wait out the update delay
    task automatic mrs(input logic [2:0] mr, input logic [15:0] v);
        int i;
        i = 0;
        cmd(1'b1, 4'h0, mr, v);
        while (busy !== 1'b0 && i < 1000) begin
            @(posedge clk_i);
            i++;
        end
        repeat (2) @(posedge clk_i);
    endtask : mrs
    // Read with junk in ignored bits; expected beats queued
    task automatic rd(input logic a2, input logic a12);
        int n, s;
        logic [15:0] a;
        logic [7:0] pat;
        pat = 8'hAA;
        n = (burst == 0 || (burst == 1 && a12)) ? 8 : 4;
        s = (n == 8 || !a2) ? 0 : 4;
        for (int i = 0; i < n; i++) begin
            q.push_back({{8{pat[s+i] & (cal == 1 && loc == 0)}},
                         pat[s+i] & (cal == 1 && loc == 0), i == n - 1});
        end
        a = 16'($urandom);
        a[2:0] = {a2, 2'b00};
        a[12] = a12;
        cmd(1'b1, 4'h5, 3'($urandom), a);
    endtask : rd
    task automatic drain(input string name);
        int i;
        i = 0;
        while (q.size() != 0 && i < 3000) begin
            @(posedge clk_i);
            i++;
        end
        repeat (40) @(posedge clk_i);
        chk(16'(q.size()), 16'h0000);
        chk({15'h0000, rd_valid_o}, 16'h0000);
        $display("test %s done", name);
    endtask : drain
    // Consumer, scoreboard and timeout
    always @(posedge clk_i) begin
        cycles++;
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
            if (q.size() == 0) begin
                chk({6'h00, rd_beat_o}, 16'hffff);
            end else begin
                chk({6'h00, rd_beat_o}, {6'h00, q.pop_front()});
            end
        end
        if (cmd_refused_o === 1'b1) begin
            n_refused++;
        end
        if (cycles == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
        rd_ready_i <= !stall && ($urandom % 4 != 0);
    end
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        stall = 1'b0;
        void'($urandom(27));
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk({10'h000, rl, cal_mode_o, dll_off_o}, 16'h0010);
        cal = 1;
        mrs(3'h3, 16'h0004);
        chk({15'h0000, cal_mode_o}, 16'h0001);
        rd(1'b0, 1'b0);
        drain("full burst");
        loc = 1;
        mrs(3'h3, 16'h0005);
        rd(1'b0, 1'b0);
        drain("reserved location");
        loc = 0;
        mrs(3'h3, 16'h0004);
        burst = 2;
        mrs(3'h0, 16'h0002);
        rd(1'b0, 1'b0);
        drain("chop low");
        rd(1'b1, 1'b0);
        drain("chop high");
        burst = 1;
        mrs(3'h0, 16'h0001);
        rd(1'b0, 1'b1);
        drain("otf full");
        rd(1'b1, 1'b0);
        drain("otf chop");
        stall = 1'b1;
        rd(1'b0, 1'b1);
        repeat (800) @(posedge clk_i);
        chk({15'h0000, rd_valid_o}, 16'h0001);
        stall = 1'b0;
        drain("fifo fill");
        base = n_refused;
        rd(1'b0, 1'b1);
        cmd(1'b1, 4'h5, 3'h0, 16'h1000);
        cmd(1'b1, 4'h1, 3'h0, 16'h0000);
        drain("refusals");
        chk(16'(n_refused - base), 16'h0002);
        rd(1'b0, 1'b1);
        cmd(1'b1, 4'h7, 3'h3, 16'h0000);
        cmd(1'b1, 4'h8, 3'h3, 16'h0000);
        drain("nop deselect");
        chk({15'h0000, cal_mode_o}, 16'h0001);
        chk(16'(n_refused - base), 16'h0002);
        cal = 0;
        mrs(3'h3, 16'h0000);
        rd(1'b0, 1'b1);
        drain("array read");
        mrs(3'h1, 16'h0001);
        chk({14'h0000, dll_off_o, bad}, 16'h0003);
        mrs(3'h0, 16'h0021);
        mrs(3'h2, 16'h0008);
        chk({9'h000, bad, rl}, 16'h0005);
        mrs(3'h1, 16'h0009);
        chk({10'h000, rl}, 16'h000a);
        rd(1'b0, 1'b1);
        drain("dll off read");
        cmd(1'b0, 4'h1, 3'h0, 16'h0000);
        chk({15'h0000, self_refresh_o}, 16'h0001);
        cmd(1'b1, 4'h7, 3'h0, 16'h0000);
        chk({15'h0000, self_refresh_o}, 16'h0000);
        mrs(3'h1, 16'h0000);
        chk({9'h000, dll_off_o, rl}, 16'h0006);
        report_and_stop();
    end
endmodule : dmdc_top_test
